/* llds_ctrl.sv */
`timescale 1ns/10ps
// Contract
// RULE1: hold command pins at no-operation while power and clock settle.
// RULE2: keep stable no-operation conditions at least 200 us before first command.
// RULE3: issue three back-to-back mode-register-set commands, two dummy then one valid.
// RULE4: device resets its internal logic from the consecutive mode-register-set run.
// RULE5: initial mode-register-set commands may go on successive cycles without recovery.
// RULE6: drive every address pin low during the dummy mode-register-set commands.
// RULE7: address bits ten to seventeen stay low during initial mode-register-set commands.
// RULE8: after recovery, refresh all 8 banks with 1,024 no-operations before normal use.
// RULE9: refreshes may sit anywhere among the no-operations; order does not matter.
// RULE10: row cycle time between a refresh and the next command to that bank.
// RULE11: refreshes need not be spaced by 2,048 no-operations.
// RULE12: clock or supply change after loop enable requires a loop reset sequence.
// RULE13: a second write to the same bank waits the row cycle time.
// RULE14: a read to the same bank waits the row cycle time.
// RULE15: remaining write burst elements follow the first on successive edges.
// RULE16: device streams back-to-back burst-of-two reads from different banks continuously.
// RULE17: wait 1,024 cycles after setting the loop reset bit before any read.
// RULE18: write data starts read latency plus one cycles after the write command.
// RULE19: device takes refresh row from its own per-bank counter; bank only supplied.
// RULE20: signal init done only after refreshes, no-operations and row cycle elapse.
module llds_ctrl
    import llds_pkg::*;
#(
    parameter int PWRUP_CYC = LLDS_PWRUP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input llds_cfg_s cfg,
    input wire logic loop_reset_req,
    input wire logic req_valid,
    output logic req_ready,
    input llds_req_s req,
    input wire logic wd_valid,
    output logic wd_ready,
    input wire logic [LLDS_DW-1:0] wd_data,
    output llds_pins_s mem_pins,
    output logic [LLDS_DW-1:0] mem_d,
    output logic mem_dm,
    input wire logic [LLDS_DW-1:0] mem_q,
    input wire logic mem_qvld,
    output logic [LLDS_DW-1:0] rd_data,
    output logic rd_valid,
    output logic init_done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    llds_st_s s;
    llds_st_s n;
    logic pop;
    logic [LLDS_DW-1:0] fifo_data;
    logic [2:0] fifo_cnt;

    function automatic llds_pins_s mk_pins(input logic [2:0] c, input logic [2:0] b,
                                           input logic [19:0] a);
        mk_pins = {c, b, a};
    endfunction

    function automatic logic [2:0] bl_beats(input logic [9:0] mode);
        bl_beats = mode[LLDS_MODE_BL_BIT] ? 3'h4 : 3'h2;
    endfunction

    function automatic logic [19:0] mode_addr(input logic [9:0] mode, input logic loop);
        logic [9:0] m;
        m = mode;
        m[LLDS_MODE_LOOP_BIT] = loop;
        mode_addr = {10'h000, m};
    endfunction

    // write data queue, drained exactly at write latency
    llds_fifo #(
        .W(LLDS_DW),
        .D(LLDS_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(wd_valid),
        .in_ready(wd_ready),
        .in_data(wd_data),
        .out_valid(),
        .out_ready(pop),
        .out_data(fifo_data),
        .count(fifo_cnt)
    );

    always_comb
    begin
        n = s;
        pop = 1'b0;
        n.pins = mk_pins(LLDS_CMD_NOP, 3'h0, 20'h0_0000);
        n.dm = 1'b1;
        // read return path, three flops from the pins
        n.q1 = mem_q;
        n.q2 = s.q1;
        n.v1 = mem_qvld;
        n.v2 = s.v1;
        n.rdq = s.q2;
        n.rdv = s.v2;
        for (int b = 0; b < LLDS_NBANK; b++)
        begin
            if (s.row_cycle_time[b] != 4'h0)
            begin
                n.row_cycle_time[b] = s.row_cycle_time[b] - 4'h1;
            end
        end
        if (s.lock != 11'h000)
        begin
            n.lock = s.lock - 11'h001;
        end
        // RULE18 latency countdown
        if (s.wbeats != 3'h0)
        begin
            if (s.wcnt > 5'h01)
            begin
                n.wcnt = s.wcnt - 5'h01;
            end
            else
            begin
                // RULE15 one element per cycle
                pop = 1'b1;
                n.d = fifo_data;
                n.dm = 1'b0;
                n.wbeats = s.wbeats - 3'h1;
            end
        end
        if (s.rdy && req_valid)
        begin
            n.pend_v = 1'b1;
            n.pend = req;
        end
        case (s.st)
            ST_STABLE:
            begin
                // RULE1 pins stay idle
                n.cnt = s.cnt + 14'h0001;
                // RULE2 stable period
                if (s.cnt == 14'(PWRUP_CYC - 1))
                begin
                    n.st = ST_MRS;
                    n.cnt = '0;
                end
            end
            ST_MRS:
            begin
                // RULE5 no recovery between these
                if (s.mrs_cnt == 2'(LLDS_NUM_MRS - 1))
                begin
                    // RULE7 upper address held low
                    n.pins = mk_pins(LLDS_CMD_MRS, 3'h0, {10'h000, cfg.mode});
                    n.lock = cfg.mode[LLDS_MODE_LOOP_BIT] ? 11'(LLDS_LOCK_CYC) : 11'h000;
                    n.st = ST_MRSC;
                    n.cnt = '0;
                end
                else
                begin
                    // RULE6 dummy with all address low
                    n.pins = mk_pins(LLDS_CMD_MRS, 3'h0, 20'h0_0000);
                end
                // RULE3 counted run of three
                n.mrs_cnt = s.mrs_cnt + 2'h1;
            end
            ST_MRSC:
            begin
                n.cnt = s.cnt + 14'h0001;
                if (s.cnt == 14'(LLDS_MRSC_CYC - 1))
                begin
                    n.st = s.done ? ST_RUN : ST_REF;
                    n.cnt = '0;
                end
            end
            ST_REF:
            begin
                // RULE8 one refresh per bank
                // RULE11 back to back, no 2,048 spacing
                n.pins = mk_pins(LLDS_CMD_REF, s.ref_cnt, 20'h0_0000);
                n.row_cycle_time[s.ref_cnt] = 4'(LLDS_TRC_CYC);
                n.ref_cnt = s.ref_cnt + 3'h1;
                if (s.ref_cnt == 3'(LLDS_NBANK - 1))
                begin
                    n.st = ST_NOPS;
                end
            end
            ST_NOPS:
            begin
                // RULE9 refreshes precede the no-operation block
                n.cnt = s.cnt + 14'h0001;
                // RULE20 done waits on every bank timer
                if (s.cnt >= 14'(LLDS_INIT_NOPS - 1) && s.row_cycle_time == '0)
                begin
                    n.st = ST_RUN;
                    n.done = 1'b1;
                    n.cnt = '0;
                end
            end
            ST_RUN:
            begin
                // RULE12 loop reset takes priority over queued work
                if (loop_reset_req)
                begin
                    n.st = ST_LOOP_LO;
                    n.cnt = '0;
                end
                // RULE10 bank timer gates every bank command
                else if (s.pend_v && s.row_cycle_time[s.pend.bank] == 4'h0)
                begin
                    case (s.pend.op)
                        LLDS_OP_READ:
                        begin
                            // RULE14 same-bank read waits
                            // RULE17 no read while the loop locks
                            if (s.lock == 11'h000)
                            begin
                                n.pins = mk_pins(LLDS_CMD_READ, s.pend.bank, s.pend.addr);
                                n.row_cycle_time[s.pend.bank] = 4'(LLDS_TRC_CYC);
                                n.pend_v = 1'b0;
                            end
                        end
                        LLDS_OP_WRITE:
                        begin
                            // RULE13 same-bank write waits
                            if (s.wbeats == 3'h0 && fifo_cnt >= bl_beats(cfg.mode))
                            begin
                                n.pins = mk_pins(LLDS_CMD_WRITE, s.pend.bank, s.pend.addr);
                                n.row_cycle_time[s.pend.bank] = 4'(LLDS_TRC_CYC);
                                n.pend_v = 1'b0;
                                n.wbeats = bl_beats(cfg.mode);
                                n.wcnt = {1'b0, cfg.rl} + 5'h01;
                            end
                        end
                        LLDS_OP_REF:
                        begin
                            n.pins = mk_pins(LLDS_CMD_REF, s.pend.bank, 20'h0_0000);
                            n.row_cycle_time[s.pend.bank] = 4'(LLDS_TRC_CYC);
                            n.pend_v = 1'b0;
                        end
                        default:
                        begin
                            // unknown op is dropped rather than wedging the queue
                            n.pend_v = 1'b0;
                        end
                    endcase
                end
            end
            ST_LOOP_LO:
            begin
                // RULE12 loop off, then recovery before turning it on
                if (s.cnt == 14'h0000)
                begin
                    n.pins = mk_pins(LLDS_CMD_MRS, 3'h0, mode_addr(cfg.mode, 1'b0));
                end
                n.cnt = s.cnt + 14'h0001;
                if (s.cnt == 14'(LLDS_MRSC_CYC))
                begin
                    n.st = ST_LOOP_HI;
                end
            end
            ST_LOOP_HI:
            begin
                // RULE17 start the lock wait
                n.pins = mk_pins(LLDS_CMD_MRS, 3'h0, mode_addr(cfg.mode, 1'b1));
                n.lock = 11'(LLDS_LOCK_CYC);
                n.st = ST_MRSC;
                n.cnt = '0;
            end
            default:
            begin
                n.st = ST_STABLE;
            end
        endcase
        n.rdy = !n.pend_v;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.pins.cs_n <= 1'b1;
            s.pins.we_n <= 1'b1;
            s.pins.ref_n <= 1'b1;
            s.dm <= 1'b1;
            s.rdy <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    assign req_ready = s.rdy;
    assign mem_pins = s.pins;
    assign mem_d = s.d;
    assign mem_dm = s.dm;
    assign rd_data = s.rdq;
    assign rd_valid = s.rdv;
    assign init_done = s.done;

    // helper logic watched only by the checks below
    logic [2:0] pc;
    logic h_mrs;
    logic [13:0] h_stab;
    logic [3:0] h_refs;
    logic [10:0] h_nops;
    logic [7:0][4:0] h_age;
    logic [4:0] h_wage;
    logic [11:0] h_lock;

    assign pc = {s.pins.cs_n, s.pins.we_n, s.pins.ref_n};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            h_mrs <= 1'b0;
            h_stab <= '0;
            h_refs <= '0;
            h_nops <= '0;
            h_age <= '1;
            h_wage <= '1;
            h_lock <= '1;
        end
        else
        begin
            if (pc == LLDS_CMD_MRS)
            begin
                h_mrs <= 1'b1;
            end
            if (!h_mrs && h_stab != '1)
            begin
                h_stab <= h_stab + 14'h0001;
            end
            if (!s.done && pc == LLDS_CMD_REF)
            begin
                h_refs <= h_refs + 4'h1;
            end
            if (!s.done && h_refs != 4'h0 && pc == LLDS_CMD_NOP && h_nops != '1)
            begin
                h_nops <= h_nops + 11'h001;
            end
            for (int b = 0; b < LLDS_NBANK; b++)
            begin
                if (pc[2] == 1'b0 && pc != LLDS_CMD_MRS && s.pins.ba == 3'(b))
                begin
                    h_age[b] <= 5'h01;
                end
                else if (h_age[b] != '1)
                begin
                    h_age[b] <= h_age[b] + 5'h01;
                end
            end
            if (pc == LLDS_CMD_WRITE)
            begin
                h_wage <= 5'h01;
            end
            else if (h_wage != '1)
            begin
                h_wage <= h_wage + 5'h01;
            end
            if (pc == LLDS_CMD_MRS && s.pins.addr[LLDS_MODE_LOOP_BIT])
            begin
                h_lock <= 12'h001;
            end
            else if (h_lock != '1)
            begin
                h_lock <= h_lock + 12'h001;
            end
        end
    end

    sequence s_mrs_run;
        pc == LLDS_CMD_MRS ##1 pc == LLDS_CMD_MRS ##1 pc == LLDS_CMD_MRS;
    endsequence

    sequence s_dummy_low;
        s.pins.addr == 20'h0_0000 ##1 s.pins.addr == 20'h0_0000;
    endsequence

    a_settle_nop: assert property (s.st == ST_STABLE |-> pc == LLDS_CMD_NOP) // RULE1
        else $error("command pins not idle during settle");
    a_stable_len: assert property ((pc == LLDS_CMD_MRS && !h_mrs) |-> h_stab >= PWRUP_CYC) // RULE2
        else $error("first mode set came too early");
    a_mrs_run: assert property ((pc == LLDS_CMD_MRS && !h_mrs) |-> s_mrs_run) // RULE3
        else $error("initial mode sets not back to back");
    a_dummy_addr: assert property ((pc == LLDS_CMD_MRS && !h_mrs) |-> s_dummy_low) // RULE6
        else $error("dummy mode set address not low");
    a_mrs_upper: assert property (pc == LLDS_CMD_MRS |-> s.pins.addr[17:10] == 8'h00) // RULE7
        else $error("upper address high on mode set");
    a_init_done: assert property ($rose(s.done) |-> h_refs == 4'h8 && h_nops >= 11'h3FF) // RULE20
        else $error("init done before refresh block complete");
    a_bank_spacing: assert property ((pc[2] == 1'b0 && pc != LLDS_CMD_MRS) // RULE10
        |-> h_age[s.pins.ba] >= 5'(LLDS_TRC_CYC))
        else $error("bank command inside row cycle time");
    a_write_lat: assert property ($fell(s.dm) |-> h_wage == {1'b0, cfg.rl} + 5'h01) // RULE18
        else $error("write data not at read latency plus one");
    a_write_beats: assert property ($fell(s.dm) |-> ##1 !s.dm) // RULE15
        else $error("write burst element missing");
    a_lock_wait: assert property (pc == LLDS_CMD_READ |-> h_lock >= 12'h400) // RULE17
        else $error("read before loop lock wait");
endmodule

/* llds_dev_model.sv */
`timescale 1ns/10ps
module llds_dev_model
    import llds_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input llds_pins_s mem_pins,
    input wire logic [LLDS_DW-1:0] mem_d,
    input wire logic mem_dm,
    input wire logic [3:0] rl,
    output logic [LLDS_DW-1:0] mem_q,
    output logic mem_qvld,
    output logic [7:0] errs
);
    typedef struct {int due; logic [LLDS_DW-1:0] d;} llds_beat_s;
    llds_beat_s rdq[$];
    logic [LLDS_DW-1:0] mem [int];
    logic [12:0] row_ctr [LLDS_NBANK];
    int last_c [LLDS_NBANK];
    int mc, run, lock_t, wdue, wkey, bl, key;
    logic up;
    logic [2:0] cmd;
    assign cmd = {mem_pins.cs_n, mem_pins.we_n, mem_pins.ref_n};
    assign key = int'({mem_pins.ba, mem_pins.addr});
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mc = 0;
            run = 0;
            up = 0;
            wdue = 0;
            lock_t = 0;
            bl = 2;
            errs = 0;
            rdq.delete();
            foreach (last_c[b])
            begin
                last_c[b] = -100;
                row_ctr[b] = 0;
            end
            mem_qvld <= 0;
            mem_q <= 0;
        end
        else
        begin
            mc = mc + 1;
            if (wdue > 0 && mc >= wdue && mc < wdue + bl && !mem_dm)
                mem[wkey + mc - wdue] = mem_d;
            if (cmd != LLDS_CMD_NOP && cmd != LLDS_CMD_MRS)
            begin
                if (!up || mc - last_c[mem_pins.ba] < LLDS_TRC_CYC)
                    errs = errs + 1;
                last_c[mem_pins.ba] = mc;
            end
            run = (cmd == LLDS_CMD_MRS) ? run + 1 : 0;
            if (run >= LLDS_NUM_MRS)
                up = 1;
            if (cmd == LLDS_CMD_MRS)
            begin
                bl = mem_pins.addr[LLDS_MODE_BL_BIT] ? 4 : 2;
                lock_t = mem_pins.addr[LLDS_MODE_LOOP_BIT] ? mc : 32'h3fff_ffff;
            end
            if (cmd == LLDS_CMD_REF)
                row_ctr[mem_pins.ba] = row_ctr[mem_pins.ba] + 1;
            if (cmd == LLDS_CMD_WRITE)
            begin
                wdue = mc + rl + 1;
                wkey = key;
            end
            if (cmd == LLDS_CMD_READ)
            begin
                if (mc - lock_t < LLDS_LOCK_CYC)
                    errs = errs + 1;
                for (int k = 0; k < bl; k++)
                    rdq.push_back('{mc + rl + k, mem.exists(key + k) ? mem[key + k] : 18'h0_0000});
            end
            if (rdq.size() > 0 && rdq[0].due == mc)
            begin
                mem_q <= rdq[0].d;
                mem_qvld <= 1;
                void'(rdq.pop_front());
            end
            else
            begin
                // idle bus flips so stale data never looks valid
                mem_q <= ~mem_q;
                mem_qvld <= 0;
            end
        end
    end
endmodule

/* llds_fifo.sv */
`timescale 1ns/10ps
module llds_fifo #(
    parameter int W = 18,
    parameter int D = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D+1)-1:0] count
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D+1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic full;
    } llds_fifo_s;

    llds_fifo_s s;
    llds_fifo_s n;
    logic push;
    logic pop;

    assign push = in_valid && !s.full;
    assign pop = out_ready && (s.cnt != '0);

    always_comb
    begin
        n = s;
        if (push)
        begin
            n.mem[s.wp] = in_data;
            n.wp = (s.wp == AW'(D - 1)) ? '0 : s.wp + AW'(1);
        end
        if (pop)
        begin
            n.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + AW'(1);
        end
        if (push && !pop)
        begin
            n.cnt = s.cnt + CW'(1);
        end
        else if (pop && !push)
        begin
            n.cnt = s.cnt - CW'(1);
        end
        // registered full keeps in_ready off any combinational path
        n.full = (n.cnt == CW'(D));
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign in_ready = !s.full;
    assign out_valid = (s.cnt != '0);
    assign out_data = s.mem[s.rp];
    assign count = s.cnt;
endmodule

/* llds_pkg.sv */
package llds_pkg;
    // timing at the 40 MHz controller clock
    localparam int LLDS_CLK_MHZ = 40;
    localparam int LLDS_PWRUP_US = 200;
    localparam int LLDS_PWRUP_CYC = LLDS_PWRUP_US * LLDS_CLK_MHZ;
    localparam int LLDS_INIT_NOPS = 1024;
    localparam int LLDS_LOCK_CYC = 1024;
    localparam int LLDS_MRSC_CYC = 4;
    localparam int LLDS_TRC_CYC = 8;
    localparam int LLDS_NUM_MRS = 3;
    localparam int LLDS_NBANK = 8;
    localparam int LLDS_DW = 18;
    localparam int LLDS_FIFO_DEPTH = 4;
    // mode word field positions
    localparam int LLDS_MODE_BL_BIT = 3;
    localparam int LLDS_MODE_LOOP_BIT = 7;
    // {cs_n, we_n, ref_n}
    localparam logic [2:0] LLDS_CMD_NOP = 3'h7;
    localparam logic [2:0] LLDS_CMD_MRS = 3'h0;
    localparam logic [2:0] LLDS_CMD_READ = 3'h3;
    localparam logic [2:0] LLDS_CMD_WRITE = 3'h1;
    localparam logic [2:0] LLDS_CMD_REF = 3'h2;
    localparam logic [1:0] LLDS_OP_READ = 2'h0;
    localparam logic [1:0] LLDS_OP_WRITE = 2'h1;
    localparam logic [1:0] LLDS_OP_REF = 2'h2;

    typedef enum logic [2:0] {
        ST_STABLE = 3'b000,
        ST_MRS = 3'b001,
        ST_MRSC = 3'b010,
        ST_REF = 3'b011,
        ST_NOPS = 3'b100,
        ST_RUN = 3'b101,
        ST_LOOP_LO = 3'b110,
        ST_LOOP_HI = 3'b111
    } llds_state_e;

    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic ref_n;
        logic [2:0] ba;
        logic [19:0] addr;
    } llds_pins_s;

    typedef struct packed {
        logic [9:0] mode;
        logic [3:0] rl;
    } llds_cfg_s;

    typedef struct packed {
        logic [1:0] op;
        logic [2:0] bank;
        logic [19:0] addr;
    } llds_req_s;

    typedef struct packed {
        llds_state_e st;
        logic [13:0] cnt;
        logic [1:0] mrs_cnt;
        logic [2:0] ref_cnt;
        logic [10:0] lock;
        logic [7:0][3:0] row_cycle_time;
        logic pend_v;
        llds_req_s pend;
        logic [4:0] wcnt;
        logic [2:0] wbeats;
        llds_pins_s pins;
        logic [17:0] d;
        logic dm;
        logic [17:0] q1;
        logic [17:0] q2;
        logic v1;
        logic v2;
        logic [17:0] rdq;
        logic rdv;
        logic done;
        logic rdy;
    } llds_st_s;
endpackage

/* low_latency_dram_powerup_seq_tb_top.sv */
`timescale 1ns/10ps
module low_latency_dram_powerup_seq_tb_top
    import llds_pkg::*;
;
    localparam int PW = 20;
    localparam int LIMIT = 10000;
    localparam logic [17:0] WB = 18'h0_0a00;
    typedef struct packed {logic [1:0] op; logic [2:0] bank; logic [19:0] addr; logic [7:0] k;} llds_row_s;
    localparam llds_row_s ROWS [7] = '{
        '{LLDS_OP_WRITE, 3'h1, 20'h0_0010, 8'h00}, '{LLDS_OP_WRITE, 3'h2, 20'h0_0020, 8'h04},
        '{LLDS_OP_READ, 3'h1, 20'h0_0010, 8'h00}, '{LLDS_OP_READ, 3'h2, 20'h0_0020, 8'h04},
        '{LLDS_OP_REF, 3'h3, 20'h0_0000, 8'h00}, '{LLDS_OP_WRITE, 3'h1, 20'h0_0014, 8'h08},
        '{LLDS_OP_READ, 3'h1, 20'h0_0014, 8'h08}};
    localparam logic [2:0] CMDS [3] = '{LLDS_CMD_READ, LLDS_CMD_WRITE, LLDS_CMD_REF};
    logic clk = 0;
    logic rst_n = 0;
    llds_cfg_s cfg = '{10'h088, 4'h4};
    logic lrr = 0;
    logic req_valid = 0;
    llds_req_s req = '0;
    logic wd_valid = 0;
    logic [17:0] wd_data = 18'h0_0000;
    logic [17:0] mem_q, mem_d, rd_data;
    logic req_ready, wd_ready, mem_dm, mem_qvld, rd_valid, init_done;
    llds_pins_s mem_pins;
    logic [7:0] errs;
    logic [7:0] mask;
    int fails = 0, comparisons = 0, cyc = 0, done_c = -1, rel_c, nw = 0, t, n, i, j;
    int ps[$];
    int ds[$];
    llds_pins_s pq[$];
    logic [17:0] dq[$];
    logic [17:0] rq[$];

    llds_ctrl #(.PWRUP_CYC(PW)) u_llds_ctrl (.clk(clk), .rst_n(rst_n), .cfg(cfg),
        .loop_reset_req(lrr), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data), .mem_pins(mem_pins),
        .mem_d(mem_d), .mem_dm(mem_dm), .mem_q(mem_q), .mem_qvld(mem_qvld),
        .rd_data(rd_data), .rd_valid(rd_valid), .init_done(init_done));
    llds_dev_model u_llds_dev_model (.clk(clk), .rst_n(rst_n), .mem_pins(mem_pins),
        .mem_d(mem_d), .mem_dm(mem_dm), .rl(cfg.rl), .mem_q(mem_q), .mem_qvld(mem_qvld),
        .errs(errs));

    always #12.5 clk = ~clk;

    task automatic give_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic push_w(input int cnt);
        for (int w = 0; w < cnt; w++)
        begin
            wd_valid <= 1;
            wd_data <= WB + nw;
            do @(posedge clk); while (wd_ready !== 1'b1);
            nw++;
        end
        wd_valid <= 0;
    endtask

    task automatic send(input llds_row_s r);
        n = pq.size();
        req_valid <= 1;
        req <= '{r.op, r.bank, r.addr};
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 0;
        for (t = 0; t < 2000 && pq.size() <= n; t++) @(posedge clk);
        chk(pq.size() > n, 1);
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc >= LIMIT)
        begin
            fails++;
            give_verdict();
        end
        if (rst_n && {mem_pins.cs_n, mem_pins.we_n, mem_pins.ref_n} !== LLDS_CMD_NOP)
        begin
            ps.push_back(cyc);
            pq.push_back(mem_pins);
        end
        if (mem_dm === 1'b0)
        begin
            ds.push_back(cyc);
            dq.push_back(mem_d);
        end
        if (rd_valid === 1'b1)
            rq.push_back(rd_data);
        if (init_done === 1'b1 && done_c < 0)
            done_c = cyc;
    end

    initial
    begin
        repeat (12) @(posedge clk);
        chk({mem_pins, mem_dm, init_done, rd_valid, req_ready, wd_ready}, 31'h7000_0013);
        rst_n <= 1;
        rel_c = cyc;
        $display("test reset done");
        for (t = 0; t < 3000 && done_c < 0; t++) @(posedge clk);
        chk(pq.size(), 11);
        chk(ps[0] - rel_c >= PW && ps[0] - rel_c <= PW + 3, 1);
        for (j = 0; j < 3; j++)
        begin
            chk({pq[j].cs_n, pq[j].we_n, pq[j].ref_n, 29'(ps[j] - ps[0])}, {3'h0, 29'(j)});
            chk(pq[j].addr, j < 2 ? 20'h0_0000 : {10'h000, cfg.mode});
        end
        mask = 8'h00;
        for (j = 3; j < 11; j++)
        begin
            chk({pq[j].cs_n, pq[j].we_n, pq[j].ref_n}, LLDS_CMD_REF);
            mask[pq[j].ba] = 1'b1;
        end
        chk(mask, 8'hff);
        chk(ps[3] - ps[2] >= LLDS_MRSC_CYC, 1);
        chk(done_c - ps[10] >= LLDS_INIT_NOPS && done_c - ps[10] >= LLDS_TRC_CYC, 1);
        $display("test init done");
        wd_data <= WB;
        wd_valid <= 1;
        for (t = 0; t < 8; t++)
        begin
            @(posedge clk);
            if (wd_ready === 1'b1)
            begin
                nw++;
                wd_data <= WB + nw;
            end
        end
        wd_valid <= 0;
        chk(nw, LLDS_FIFO_DEPTH);
        $display("test fifo full done");
        for (i = 0; i < 7; i++)
        begin
            ds.delete();
            dq.delete();
            rq.delete();
            if (i > 0 && ROWS[i].op == LLDS_OP_WRITE)
                push_w(4);
            send(ROWS[i]);
            chk({pq[n].cs_n, pq[n].we_n, pq[n].ref_n}, CMDS[ROWS[i].op]);
            chk(pq[n].ba, ROWS[i].bank);
            if (ROWS[i].op != LLDS_OP_REF)
                chk(pq[n].addr, ROWS[i].addr);
            if (i == 6)
                chk(ps[n] - ps[n - 1] >= LLDS_TRC_CYC, 1);
            for (t = 0; t < 100 && ROWS[i].op != LLDS_OP_REF && dq.size() + rq.size() < 4; t++)
                @(posedge clk);
            for (j = 0; j < 4 && ROWS[i].op == LLDS_OP_WRITE; j++)
            begin
                chk(ds[j] - ps[n], cfg.rl + 1 + j);
                chk(dq[j], WB + ROWS[i].k + j);
            end
            for (j = 0; j < 4 && ROWS[i].op == LLDS_OP_READ; j++)
                chk(rq[j], WB + ROWS[i].k + j);
            $display("test row %0d done", i);
        end
        // undefined op must be dropped without a command or a stuck holder
        n = pq.size();
        req_valid <= 1;
        req <= '{2'h3, 3'h4, 20'h0_0000};
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 0;
        repeat (4) @(posedge clk);
        chk({req_ready, 31'(pq.size() - n)}, 32'h8000_0000);
        $display("test bad op done");
        n = pq.size();
        lrr <= 1;
        @(posedge clk);
        lrr <= 0;
        for (t = 0; t < 50 && pq.size() < n + 2; t++) @(posedge clk);
        chk({pq[n].addr[7], pq[n + 1].addr[7]}, 2'h1);
        chk(ps[n + 1] - ps[n] >= LLDS_MRSC_CYC, 1);
        send(ROWS[3]);
        chk(ps[n] - ps[n - 1] >= LLDS_LOCK_CYC, 1);
        repeat (20) @(posedge clk);
        chk(errs, 0);
        $display("test loop reset done");
        give_verdict();
    end
endmodule
